// file: inc/blic_pkg.sv
// Constants and carrier types of the board logic interrupt combiner
package blic_pkg;

  // ==========================================================================
  // Bus geometry
  // ==========================================================================
  localparam int unsigned APB_AW     = 12;
  localparam int unsigned APB_DW     = 32;
  localparam int unsigned REG_W      = 8;
  localparam int unsigned NSRC       = 5;

  // ==========================================================================
  // Register indices as printed, byte address is four times the index
  // ==========================================================================
  localparam logic [9:0] IDX_CTRL    = 10'h1e3;
  localparam logic [9:0] IDX_MASK    = 10'h1e4;
  localparam logic [9:0] IDX_STAT    = 10'h1e5;
  localparam logic [9:0] IDX_LIVE    = 10'h1f0;
  localparam logic [9:0] IDX_PEND    = 10'h1f1;

  localparam logic [APB_AW-1:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [APB_AW-1:0] ADDR_MASK = {IDX_MASK, 2'b00};
  localparam logic [APB_AW-1:0] ADDR_STAT = {IDX_STAT, 2'b00};
  localparam logic [APB_AW-1:0] ADDR_LIVE = {IDX_LIVE, 2'b00};
  localparam logic [APB_AW-1:0] ADDR_PEND = {IDX_PEND, 2'b00};

  // ==========================================================================
  // Field layout
  // ==========================================================================
  localparam int unsigned CTRL_EN_BIT   = 4;
  localparam int unsigned CTRL_SEL_LSB  = 0;
  localparam int unsigned CTRL_SEL_W    = 4;
  localparam logic [3:0]  CTRL_SEL_PASS = 4'h0;
  localparam logic [7:0]  CTRL_WMASK    = 8'h1f;

  localparam int unsigned SRC_TC0    = 0;
  localparam int unsigned SRC_TC1    = 1;
  localparam int unsigned SRC_TC2    = 2;
  localparam int unsigned SRC_SERR   = 3;
  localparam int unsigned SRC_PERR   = 4;

  localparam int unsigned PEND_IRQ_BIT = 7;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0]      RST_CTRL = 8'h00;
  localparam logic [NSRC-1:0] RST_MASK = 5'h00;
  localparam logic [NSRC-1:0] RST_STAT = 5'h00;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [APB_AW-1:0] paddr;
    logic [APB_DW-1:0] pwdata;
    logic [3:0]        pstrb;
  } blic_apb_req_s;

  typedef struct packed {
    logic              pready;
    logic              pslverr;
    logic [APB_DW-1:0] prdata;
  } blic_apb_rsp_s;

endpackage

// file: logic/blic_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps

module blic_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] stable;
  } blic_sync_state_s;

  blic_sync_state_s q;
  blic_sync_state_s d;

  // ==========================================================================
  // Next state: s1 feeds only s2; output follows once s2 and s3 agree
  // ==========================================================================
  always_comb begin
    d        = q;
    d.s1     = din;
    d.s2     = q.s1;
    d.s3     = q.s2;
    d.stable = (q.s2 & q.s3) | (q.stable & (q.s2 ^ q.s3));
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign dout = q.stable;

endmodule

// file: logic/blic_top.sv
// Board logic interrupt combiner: source latching, masking, APB registers
`timescale 1ns/100ps

// Overview of operation
// - The combined interrupt leaves on the pin wired to host GPIO port 1 bit 6.
// - Control bit 4 is the global enable; 0 blocks the interrupt output, 1 allows it.
// - Control bits 3:0 reset to 0000 and any other value disables the output.
// - The mask decides which latched status bits may raise the output.
// - Mask bit 4 admits the parity error source.
// - Mask bit 3 admits the system error source.
// - Mask bits 2, 1, 0 admit timer 2, timer 1 and timer 0 terminal counts.
// - A timer status bit sets on a 0 to 1 change of its output and sticks.
// - Writing 1 to a status bit clears it; writing 0 leaves it.
// - Status latches regardless of mask, and PERR and SERR assertions latch too.

module blic_top (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire blic_pkg::blic_apb_req_s apb_req,
  output blic_pkg::blic_apb_rsp_s     apb_rsp,
  input  wire logic                   perr_n,
  input  wire logic                   serr_n,
  input  wire logic [2:0]             timer_out,
  output logic                        irq_to_gpio_port1_bit6
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [7:0]                ctrl;
    logic [blic_pkg::NSRC-1:0] mask;
    logic [blic_pkg::NSRC-1:0] stat;
    logic [blic_pkg::NSRC-1:0] lvl_prev;
    logic                      irq;
    logic                      pready;
    logic                      pslverr;
    logic [31:0]               prdata;
  } blic_state_s;

  blic_state_s q;
  blic_state_s d;

  // ==========================================================================
  // Source conditioning
  // ==========================================================================
  logic [blic_pkg::NSRC-1:0] src_raw;
  logic [blic_pkg::NSRC-1:0] src_lvl;

  // PCI error pins are active low; present every source as asserted-high
  always_comb begin
    src_raw                    = '0;
    src_raw[blic_pkg::SRC_TC0]  = timer_out[0];
    src_raw[blic_pkg::SRC_TC1]  = timer_out[1];
    src_raw[blic_pkg::SRC_TC2]  = timer_out[2];
    src_raw[blic_pkg::SRC_SERR] = ~serr_n;
    src_raw[blic_pkg::SRC_PERR] = ~perr_n;
  end

  blic_sync #(
    .WIDTH (blic_pkg::NSRC)
  ) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .din  (src_raw),
    .dout (src_lvl)
  );

  // ==========================================================================
  // Combinational helpers
  // ==========================================================================
  logic                      setup_ph;
  logic                      access_ph;
  logic                      addr_aligned;
  logic                      hit_ctrl;
  logic                      hit_mask;
  logic                      hit_stat;
  logic                      hit_live;
  logic                      hit_pend;
  logic                      addr_hit;
  logic                      wr_lane0;
  logic [blic_pkg::NSRC-1:0] rise;
  logic [blic_pkg::NSRC-1:0] stat_clr;
  logic [blic_pkg::NSRC-1:0] pending;
  logic                      global_en;
  logic                      sel_pass;

  assign setup_ph     = apb_req.psel & ~apb_req.penable;
  assign access_ph    = apb_req.psel & apb_req.penable & q.pready;
  assign addr_aligned = (apb_req.paddr[1:0] == 2'b00);
  assign hit_ctrl     = addr_aligned & (apb_req.paddr == blic_pkg::ADDR_CTRL);
  assign hit_mask     = addr_aligned & (apb_req.paddr == blic_pkg::ADDR_MASK);
  assign hit_stat     = addr_aligned & (apb_req.paddr == blic_pkg::ADDR_STAT);
  assign hit_live     = addr_aligned & (apb_req.paddr == blic_pkg::ADDR_LIVE);
  assign hit_pend     = addr_aligned & (apb_req.paddr == blic_pkg::ADDR_PEND);
  assign addr_hit     = hit_ctrl | hit_mask | hit_stat | hit_live | hit_pend;
  // Registers are eight bits wide, so only byte lane 0 carries a write
  assign wr_lane0     = access_ph & apb_req.pwrite & ~q.pslverr & apb_req.pstrb[0];

  // Rising edge of each conditioned source; PERR/SERR count on assertion
  assign rise = src_lvl & ~q.lvl_prev;

  assign stat_clr = (wr_lane0 & hit_stat) ?
                    apb_req.pwdata[blic_pkg::NSRC-1:0] : '0;

  // Status gated by the mask; bits with mask 0 never reach the output
  assign pending   = q.stat & q.mask;
  assign global_en = q.ctrl[blic_pkg::CTRL_EN_BIT];
  assign sel_pass  = (q.ctrl[blic_pkg::CTRL_SEL_LSB +: blic_pkg::CTRL_SEL_W] ==
                      blic_pkg::CTRL_SEL_PASS);

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    d          = q;
    d.lvl_prev = src_lvl;

    // Latch regardless of mask; a new event wins over a clear in the same cycle
    d.stat = (q.stat & ~stat_clr) | rise;

    // Register writes take effect at the access edge only
    if (wr_lane0 && hit_ctrl) begin
      // Reserved bits are never stored, so they read back as zero
      d.ctrl = apb_req.pwdata[7:0] & blic_pkg::CTRL_WMASK;
    end
    if (wr_lane0 && hit_mask) begin
      d.mask = apb_req.pwdata[blic_pkg::NSRC-1:0];
    end

    // Zero-wait slave: answer is prepared in setup, shown in access
    d.pready  = setup_ph;
    d.pslverr = 1'b0;
    d.prdata  = 32'h0000_0000;
    if (setup_ph) begin
      d.pslverr = ~addr_hit;
      unique case (1'b1)
        hit_ctrl: begin
          d.prdata[7:0] = q.ctrl;
        end
        hit_mask: begin
          d.prdata[blic_pkg::NSRC-1:0] = q.mask;
        end
        hit_stat: begin
          d.prdata[blic_pkg::NSRC-1:0] = q.stat;
        end
        hit_live: begin
          d.prdata[blic_pkg::NSRC-1:0] = src_lvl;
        end
        hit_pend: begin
          d.prdata[blic_pkg::NSRC-1:0]    = pending;
          d.prdata[blic_pkg::PEND_IRQ_BIT] = q.irq;
        end
        default: begin
          d.prdata = 32'h0000_0000;
        end
      endcase
    end

    // Combined level output toward the host GPIO
    d.irq = global_en & sel_pass & (|pending);
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (!nrst) begin
      q.ctrl     <= blic_pkg::RST_CTRL;
      q.mask     <= blic_pkg::RST_MASK;
      q.stat     <= blic_pkg::RST_STAT;
      q.lvl_prev <= '0;
      q.irq      <= 1'b0;
      q.pready   <= 1'b0;
      q.pslverr  <= 1'b0;
      q.prdata   <= 32'h0000_0000;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // Outputs, straight from flip-flops
  // ==========================================================================
  assign apb_rsp.pready  = q.pready;
  assign apb_rsp.pslverr = q.pslverr;
  assign apb_rsp.prdata  = q.prdata;

  assign irq_to_gpio_port1_bit6 = q.irq;

endmodule

// file: dv/blic_properties.sv
// Port-level checker for the interrupt combiner
`timescale 1ns/100ps

module blic_properties (
  input wire logic                    clk,
  input wire logic                    nrst,
  input wire blic_pkg::blic_apb_req_s apb_req,
  input wire blic_pkg::blic_apb_rsp_s apb_rsp,
  input wire logic                    perr_n,
  input wire logic                    serr_n,
  input wire logic [2:0]              timer_out,
  input wire logic                    irq_to_gpio_port1_bit6
);
  // ==========================================================================
  // Shadow of the control and mask registers, snooped from completed writes
  // ==========================================================================
  logic [7:0] ctrl_q;
  logic [4:0] mask_q;
  logic       wr_q;
  logic       acc_wr;
  logic       mapped;
  assign acc_wr = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite
                  && apb_req.pstrb[0];
  assign mapped = apb_req.paddr inside {blic_pkg::ADDR_CTRL, blic_pkg::ADDR_MASK,
                  blic_pkg::ADDR_STAT, blic_pkg::ADDR_LIVE, blic_pkg::ADDR_PEND};
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_q <= 8'h00;
      mask_q <= 5'h00;
      wr_q   <= 1'b0;
    end else begin
      wr_q <= acc_wr;
      if (acc_wr && apb_req.paddr == blic_pkg::ADDR_CTRL) begin
        ctrl_q <= apb_req.pwdata[7:0] & blic_pkg::CTRL_WMASK;
      end
      if (acc_wr && apb_req.paddr == blic_pkg::ADDR_MASK) begin
        mask_q <= apb_req.pwdata[4:0];
      end
    end
  end

  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence setup_s;
    apb_req.psel && !apb_req.penable;
  endsequence
  sequence perr_armed_s;
    $fell(perr_n) && ctrl_q == 8'h10 && mask_q[4];
  endsequence
  a_ready_after_setup: assert property (setup_s |=> apb_rsp.pready)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready stood too long");
  a_err_on_unmapped: assert property (setup_s and !mapped |=> apb_rsp.pslverr)
    else $error("no error for unmapped address");
  a_enable_blocks_irq: assert property (!ctrl_q[4] |=> !irq_to_gpio_port1_bit6)
    else $error("irq high with enable clear");
  a_select_blocks_irq: assert property (ctrl_q[3:0] != 4'h0 |=> !irq_to_gpio_port1_bit6)
    else $error("irq high with select nonzero");
  a_mask_blocks_irq: assert property (mask_q == 5'h00 |=> !irq_to_gpio_port1_bit6)
    else $error("irq high with all sources masked");
  a_parity_raises_irq: assert property (perr_armed_s |-> ##[1:8] irq_to_gpio_port1_bit6)
    else $error("parity error did not raise irq");
  a_irq_stays_set: assert property (irq_to_gpio_port1_bit6 && !acc_wr && !wr_q
    |=> irq_to_gpio_port1_bit6)
    else $error("irq dropped without a write");
endmodule

// file: dv/blic_host_gpio.sv
// Host processor GPIO interrupt input and its port routing
`timescale 1ns/100ps

module blic_host_gpio (
  input  wire logic       clk,
  input  wire logic       gpio_in,
  input  wire logic [7:0] port_mask,
  input  wire logic [7:0] port_ctrl,
  input  wire logic [7:0] port_mode,
  output logic            host_irq,
  output logic [4:0]      irq_num
);
  localparam logic [4:0] IRQ_MAP [16] = '{5'h0, 5'h9, 5'h3, 5'ha, 5'h4, 5'h5, 5'h7, 5'h6,
                                          5'h1, 5'hb, 5'h0, 5'hc, 5'h0, 5'he, 5'h0, 5'hf};
  logic prev_q;
  logic routed;
  always_ff @(posedge clk) prev_q <= gpio_in;
  assign routed   = port_mask == 8'h40 && port_ctrl[7] && port_ctrl[6:4] == 3'h0;
  assign irq_num  = IRQ_MAP[port_ctrl[3:0]];
  // Level mode follows the pin; edge mode gives one pulse per rise
  assign host_irq = routed && irq_num != 5'h0
                    && (port_mode == 8'h40 ? gpio_in : gpio_in && !prev_q);
endmodule

// file: dv/tb_board_logic_interrupt_combiner.sv
// Self-checking bench for the interrupt combiner
`timescale 1ns/100ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end

module tb_board_logic_interrupt_combiner;
  logic                    clk;
  logic                    nrst;
  logic                    irq;
  logic                    host_irq;
  logic [4:0]              irq_num;
  logic [4:0]              src;
  logic [7:0]              rd;
  logic                    err;
  logic [7:0]              c;
  logic [7:0]              m;
  logic [2:0]              s;
  logic                    e;
  blic_pkg::blic_apb_req_s req;
  blic_pkg::blic_apb_rsp_s rsp;
  int                      n_errors = 0;
  int                      checks_done = 0;
  // Control, mask, source index, expected irq
  logic [19:0] rows [8] = '{{8'h10, 8'h01, 3'h0, 1'h1}, {8'h10, 8'h02, 3'h1, 1'h1},
                            {8'h10, 8'h04, 3'h2, 1'h1}, {8'h10, 8'h08, 3'h3, 1'h1},
                            {8'h10, 8'h10, 3'h4, 1'h1}, {8'h10, 8'h0f, 3'h4, 1'h0},
                            {8'h00, 8'h1f, 3'h0, 1'h0}, {8'h11, 8'h1f, 3'h1, 1'h0}};

  blic_top uut (.clk(clk), .nrst(nrst), .apb_req(req), .apb_rsp(rsp), .perr_n(~src[4]),
    .serr_n(~src[3]), .timer_out(src[2:0]), .irq_to_gpio_port1_bit6(irq));
  blic_host_gpio host (.clk(clk), .gpio_in(irq), .port_mask(8'h40), .port_ctrl(8'h81),
    .port_mode(8'h40), .host_irq(host_irq), .irq_num(irq_num));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One APB transfer; waits for pready, takes data at that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h00_0000, d},
             pstrb: 4'hf};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (rsp.pready !== 1'b1);
    rd  = rsp.prdata[7:0];
    err = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    wt(5000);
    n_errors++;
    close_out;
  end

  initial begin
    req  = '0;
    src  = 5'h00;
    nrst = 1'b0;
    wt(5);
    nrst <= 1'b1;
    apb(0, blic_pkg::ADDR_CTRL, 8'h00);
    `CHK(rd, 8'h00)
    apb(0, blic_pkg::ADDR_MASK, 8'h00);
    `CHK(rd, 8'h00)
    apb(0, 12'h7fc, 8'h00);
    `CHK(err, 1'b1)
    `CHK(irq_num, 5'h09)
    $display("reset test done");
    foreach (rows[i]) begin
      {c, m, s, e} = rows[i];
      apb(1, blic_pkg::ADDR_CTRL, c);
      apb(1, blic_pkg::ADDR_MASK, m);
      src[s] <= 1'b1;
      wt(8);
      src[s] <= 1'b0;
      wt(4);
      apb(0, blic_pkg::ADDR_STAT, 8'h00);
      `CHK(rd, 8'h01 << s)
      `CHK(irq, e)
      `CHK(host_irq, e)
      apb(1, blic_pkg::ADDR_STAT, 8'h1f);
      apb(0, blic_pkg::ADDR_STAT, 8'h00);
      `CHK(rd, 8'h00)
      `CHK(irq, 1'b0)
      $display("row %0d done", i);
    end
    apb(1, blic_pkg::ADDR_CTRL, 8'h10);
    apb(1, blic_pkg::ADDR_MASK, 8'h01);
    src[0] <= 1'b1;
    wt(6);
    apb(0, blic_pkg::ADDR_LIVE, 8'h00);
    `CHK(rd, 8'h01)
    src[0] <= 1'b0;
    apb(1, blic_pkg::ADDR_STAT, 8'h1e);
    apb(0, blic_pkg::ADDR_PEND, 8'h00);
    `CHK(rd, 8'h81)
    apb(1, blic_pkg::ADDR_CTRL, 8'h00);
    wt(2);
    `CHK(irq, 1'b0)
    apb(1, blic_pkg::ADDR_CTRL, 8'h18);
    wt(2);
    `CHK(irq, 1'b0)
    apb(1, blic_pkg::ADDR_CTRL, 8'h10);
    wt(2);
    `CHK(irq, 1'b1)
    $display("sticky and gating test done");
    nrst <= 1'b0;
    wt(2);
    `CHK(irq, 1'b0)
    wt(4);
    nrst <= 1'b1;
    apb(0, blic_pkg::ADDR_CTRL, 8'h00);
    `CHK(rd, 8'h00)
    apb(0, blic_pkg::ADDR_MASK, 8'h00);
    `CHK(rd, 8'h00)
    $display("mid-run reset test done");
    close_out;
  end
endmodule

bind blic_top blic_properties chk (.clk(clk), .nrst(nrst), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .perr_n(perr_n), .serr_n(serr_n), .timer_out(timer_out),
  .irq_to_gpio_port1_bit6(irq_to_gpio_port1_bit6));
